// ---- rtl/ecmai_top.v ----
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/100ps
// How it works
// - With frame alignment, timeslot 16 of each frame is searched by a selectable algorithm.
// - Algorithm one: 15 frames without pattern, then a pattern frame, gives alignment.
// - Algorithm two: nonzero bits 1-4 followed by pattern gives alignment.
// - When aligned, the lost flag goes low and pattern errors are flagged.
// - While aligned, report debounced remote multiframe alarm, bit 6 of frame 0.
// - Debounced remote alarm sets after two consecutive ones.
// - Two all-ones timeslot 16 bytes while unaligned raise an event.
// - Two consecutive errored alignment patterns lose multiframe alignment.
// - Timeslot 16 all zero for one or two multiframes loses alignment.
// - Loss of frame alignment loses multiframe alignment.
// - Frame-loss and all-ones alarms set and clear after about 100 ms.
// - All-ones event: fewer than 3 zeros in 512 bits.
// - Interval valid for all-ones when 13 of 16 events occurred.
// - All-ones counter counts up or down; alarm at 25, removed at zero.
// - Slot 16 all-ones counter; alarm at 22, removed at zero.
// - Interval is out-of-frame if any frame loss seen, else in frame.
// - Red counter up on lost intervals, down otherwise; alarm 25, off at 0.
// - A change of frame-lost, multiframe-lost, all-ones or red status can be flagged for interrupt.
`include "ecmai_map.vh"
module ecmai_top #(
   parameter INTERVAL_CYCLES = 40000
) (
   input  wire        clk,
   input  wire        reset_n,
   input  wire        line_bit,
   input  wire        line_bit_valid,
   input  wire        frame_sync_lost,
   input  wire        slot16_strobe,
   input  wire [7:0]  slot16_byte,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   output reg         status_change,
   output reg         sig_multiframe_lost,
   output reg         all_ones_alarm,
   output reg         red_alarm,
   output reg         slot16_alarm
);
   // ****************************************
   // Pin synchronisers
   // ****************************************
   reg [2:0] sync_a;
   reg [2:0] sync_b;
   wire      s_bit;
   wire      s_bv;
   wire      s_fsl;
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sync_a <= 3'h0;
         sync_b <= 3'h0;
      end else begin
         sync_a <= {line_bit, line_bit_valid, frame_sync_lost};
         sync_b <= sync_a;
      end
   end
   assign s_bit = sync_b[2];
   assign s_bv  = sync_b[1];
   assign s_fsl = sync_b[0];
   // Slot 16 byte and strobe come from framer logic on this clock
   // ****************************************
   // Registers and APB
   // ****************************************
   reg [1:0]  ctrl;
   reg [3:0]  chg_mask;
   reg [3:0]  change;
   reg [2:0]  event_flag;
   reg        remote_mf;
   wire       wr_en = psel & penable & pwrite;
   wire       rd_en = psel & penable & ~pwrite;
   wire [3:0] stat4 = {red_alarm, all_ones_alarm, sig_multiframe_lost, s_fsl};
   reg  [3:0] stat_q;
   wire [3:0] stat_diff = stat4 ^ stat_q;
   wire       mapped = (paddr == `ECMAI_CTRL_ADDR) | (paddr == `ECMAI_STATUS_ADDR) |
                       (paddr == `ECMAI_CHANGE_ADDR) | (paddr == `ECMAI_CHG_MASK_ADDR) |
                       (paddr == `ECMAI_EVENT_ADDR);
   reg [2:0]  ev_set;
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl       <= `ECMAI_CTRL_RESET;
         chg_mask   <= `ECMAI_MASK_RESET;
         change     <= 4'h0;
         event_flag <= 3'h0;
         // The lost flag resets high; seed its copy so reset is not seen as a change
         stat_q     <= 4'h2;
         prdata     <= 32'h0;
         pready     <= 1'b0;
         pslverr    <= 1'b0;
         status_change <= 1'b0;
      end else begin
         stat_q <= stat4;
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & ~mapped;
         if (wr_en && pready && paddr == `ECMAI_CTRL_ADDR) begin
            ctrl <= pwdata[1:0];
         end
         if (wr_en && pready && paddr == `ECMAI_CHG_MASK_ADDR) begin
            chg_mask <= pwdata[3:0];
         end
         // Write one to clear; a new change in the same cycle wins
         if (wr_en && pready && paddr == `ECMAI_CHANGE_ADDR) begin
            change <= (change & ~pwdata[3:0]) | stat_diff;
         end else begin
            change <= change | stat_diff;
         end
         if (wr_en && pready && paddr == `ECMAI_EVENT_ADDR) begin
            event_flag <= (event_flag & ~pwdata[2:0]) | ev_set;
         end else begin
            event_flag <= event_flag | ev_set;
         end
         status_change <= |(change & chg_mask);
         if (psel && !penable) begin
            case (paddr)
               `ECMAI_CTRL_ADDR:     prdata <= {30'h0, ctrl};
               `ECMAI_STATUS_ADDR:   prdata <= {26'h0, remote_mf, slot16_alarm, stat4};
               `ECMAI_CHANGE_ADDR:   prdata <= {28'h0, change};
               `ECMAI_CHG_MASK_ADDR: prdata <= {28'h0, chg_mask};
               `ECMAI_EVENT_ADDR:    prdata <= {29'h0, event_flag};
               default:              prdata <= 32'h0;
            endcase
         end
      end
   end
   // ****************************************
   // Signalling multiframe find
   // ****************************************
   localparam ST_SEARCH = 1'b0;
   localparam ST_SYNC   = 1'b1;
   reg       smf_state;
   reg [3:0] mf_pos;
   reg [3:0] miss_run;
   reg       prev_nonzero;
   reg [1:0] err_run;
   reg [4:0] zero_frames;
   reg       prev_ones;
   reg [1:0] remote_run;
   reg       ais_event;
   wire      pattern_ok = (slot16_byte[7:4] == 4'h0);
   wire      ts_zero    = (slot16_byte == 8'h00);
   wire      ts_ones    = (slot16_byte == 8'hff);
   wire [4:0] zero_limit = ctrl[`ECMAI_CTRL_ZERO_MF2] ? 5'd31 : 5'd15;
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         smf_state <= ST_SEARCH;
         sig_multiframe_lost <= 1'b1;
         mf_pos <= 4'h0;
         miss_run <= 4'h0;
         prev_nonzero <= 1'b0;
         err_run <= 2'h0;
         zero_frames <= 5'h0;
         prev_ones <= 1'b0;
         remote_run <= 2'h0;
         remote_mf <= 1'b0;
         ev_set <= 3'h0;
      end else begin
         ev_set[`ECMAI_EV_MF_ERROR]  <= 1'b0;
         ev_set[`ECMAI_EV_TS16_ONES] <= 1'b0;
         if (s_fsl) begin
            smf_state <= ST_SEARCH;
            sig_multiframe_lost <= 1'b1;
            miss_run <= 4'h0;
            prev_nonzero <= 1'b0;
            remote_mf <= 1'b0;
            remote_run <= 2'h0;
         end else if (slot16_strobe) begin
            prev_ones <= ts_ones;
            ev_set[`ECMAI_EV_TS16_ONES] <= sig_multiframe_lost & ts_ones & prev_ones;
            mf_pos <= mf_pos + 4'h1;
            case (smf_state)
               ST_SEARCH: begin
                  prev_nonzero <= (slot16_byte[7:4] != 4'h0);
                  miss_run <= pattern_ok ? 4'h0 : ((miss_run == 4'hf) ? miss_run : miss_run + 4'h1);
                  if (pattern_ok && (ctrl[`ECMAI_CTRL_ALG2] ? prev_nonzero
                                                           : (miss_run == 4'hf))) begin
                     smf_state <= ST_SYNC;
                     sig_multiframe_lost <= 1'b0;
                     mf_pos <= 4'h1;
                     err_run <= 2'h0;
                     zero_frames <= 5'h0;
                  end
               end
               ST_SYNC: begin
                  zero_frames <= ts_zero ? zero_frames + 5'h1 : 5'h0;
                  if (mf_pos == 4'h0) begin
                     ev_set[`ECMAI_EV_MF_ERROR] <= ~pattern_ok;
                     err_run <= pattern_ok ? 2'h0 : err_run + 2'h1;
                     remote_run <= slot16_byte[2] ? ((remote_run == `ECMAI_REMOTE_RUN) ?
                                    remote_run : remote_run + 2'h1) : 2'h0;
                     remote_mf <= slot16_byte[2] ? (remote_run >= 2'd1) : 1'b0;
                  end
                  if ((mf_pos == 4'h0 && !pattern_ok && err_run + 2'h1 == `ECMAI_MFAS_ERR_LOSS) ||
                      (ts_zero && zero_frames >= zero_limit)) begin
                     smf_state <= ST_SEARCH;
                     sig_multiframe_lost <= 1'b1;
                     // Clear search and debounce history so nothing stale survives the loss
                     miss_run <= 4'h0;
                     prev_nonzero <= 1'b0;
                     remote_run <= 2'h0;
                     remote_mf <= 1'b0;
                  end
               end
               default: smf_state <= ST_SEARCH;
            endcase
         end
         ev_set[`ECMAI_EV_AIS_DETECT] <= ais_event;
      end
   end
   // ****************************************
   // All-ones detection over 512 bits
   // ****************************************
   reg [8:0] bit_cnt;
   reg [1:0] zero_cnt;
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         bit_cnt <= 9'h0;
         zero_cnt <= 2'h0;
         ais_event <= 1'b0;
      end else begin
         ais_event <= 1'b0;
         if (s_bv) begin
            bit_cnt <= bit_cnt + 9'h1;
            if (bit_cnt == 9'h1ff) begin
               // A saturated count plus a last zero must not wrap back to a small value
               ais_event <= s_bit ? (zero_cnt < `ECMAI_AIS_ZERO_LIMIT) :
                                    (zero_cnt < `ECMAI_AIS_ZERO_LIMIT - 2'h1);
               zero_cnt <= 2'h0;
            end else if (!s_bit && zero_cnt != `ECMAI_AIS_ZERO_LIMIT) begin
               zero_cnt <= zero_cnt + 2'h1;
            end
         end
      end
   end
   // ****************************************
   // Alarm integration
   // ****************************************
   reg [16:0] tick_cnt;
   reg        tick;
   reg [4:0]  ais_events;
   reg        oof_seen;
   reg        ts16_seen;
   reg [4:0]  ais_int;
   reg [4:0]  red_int;
   reg [4:0]  ts16_int;
   wire       ts16_now = ev_set[`ECMAI_EV_TS16_ONES];
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tick_cnt <= 17'h0;
         tick <= 1'b0;
         ais_events <= 5'h0;
         oof_seen <= 1'b0;
         ts16_seen <= 1'b0;
         ais_int <= 5'h0;
         red_int <= 5'h0;
         ts16_int <= 5'h0;
         all_ones_alarm <= 1'b0;
         red_alarm <= 1'b0;
         slot16_alarm <= 1'b0;
      end else begin
         tick <= (tick_cnt == INTERVAL_CYCLES - 1);
         tick_cnt <= (tick_cnt == INTERVAL_CYCLES - 1) ? 17'h0 : tick_cnt + 17'h1;
         if (tick) begin
            ais_events <= {4'h0, ais_event};
            oof_seen <= s_fsl;
            ts16_seen <= ts16_now;
            if (ais_events >= `ECMAI_AIS_VALID_MIN) begin
               ais_int <= (ais_int == `ECMAI_AIS_SET) ? ais_int : ais_int + 5'h1;
            end else begin
               ais_int <= (ais_int == 5'h0) ? ais_int : ais_int - 5'h1;
            end
            if (oof_seen) begin
               red_int <= (red_int == `ECMAI_RED_SET) ? red_int : red_int + 5'h1;
            end else begin
               red_int <= (red_int == 5'h0) ? red_int : red_int - 5'h1;
            end
            if (ts16_seen) begin
               ts16_int <= (ts16_int == `ECMAI_TS16_SET) ? ts16_int : ts16_int + 5'h1;
            end else begin
               ts16_int <= (ts16_int == 5'h0) ? ts16_int : ts16_int - 5'h1;
            end
         end else begin
            if (ais_event && ais_events != 5'h1f) begin
               ais_events <= ais_events + 5'h1;
            end
            oof_seen <= oof_seen | s_fsl;
            ts16_seen <= ts16_seen | ts16_now;
         end
         // Hysteresis: set at threshold, cleared only at zero
         if (ais_int == `ECMAI_AIS_SET) all_ones_alarm <= 1'b1;
         else if (ais_int == 5'h0) all_ones_alarm <= 1'b0;
         if (red_int == `ECMAI_RED_SET) red_alarm <= 1'b1;
         else if (red_int == 5'h0) red_alarm <= 1'b0;
         if (ts16_int == `ECMAI_TS16_SET) slot16_alarm <= 1'b1;
         else if (ts16_int == 5'h0) slot16_alarm <= 1'b0;
      end
   end
endmodule

// ---- rtl/ecmai_map.vh ----
`ifndef ECMAI_MAP_VH
`define ECMAI_MAP_VH
// ****************************************
// Register offsets
// ****************************************
`define ECMAI_CTRL_ADDR        12'h000
`define ECMAI_STATUS_ADDR      12'h004
`define ECMAI_CHANGE_ADDR      12'h008
`define ECMAI_CHG_MASK_ADDR    12'h00c
`define ECMAI_EVENT_ADDR       12'h010
// ****************************************
// Field positions
// ****************************************
`define ECMAI_CTRL_ALG2        0
`define ECMAI_CTRL_ZERO_MF2    1
`define ECMAI_ST_FRAME_LOST    0
`define ECMAI_ST_SMF_LOST      1
`define ECMAI_ST_AIS_ALARM     2
`define ECMAI_ST_RED_ALARM     3
`define ECMAI_ST_TS16_ALARM    4
`define ECMAI_ST_REMOTE_MF     5
`define ECMAI_EV_MF_ERROR      0
`define ECMAI_EV_TS16_ONES     1
`define ECMAI_EV_AIS_DETECT    2
// ****************************************
// Reset values and counts
// ****************************************
`define ECMAI_CTRL_RESET       2'h0
`define ECMAI_MASK_RESET       4'h0
`define ECMAI_INTERVAL_MS      4
`define ECMAI_AIS_SET          5'd25
`define ECMAI_TS16_SET         5'd22
`define ECMAI_RED_SET          5'd25
`define ECMAI_AIS_VALID_MIN    5'd13
`define ECMAI_AIS_ZERO_LIMIT   2'd3
`define ECMAI_AIS_WINDOW_BITS  512
`define ECMAI_MFAS_ERR_LOSS    2'd2
`define ECMAI_REMOTE_RUN       2'd2
`endif

// ---- verif/ecmai_monitor.sv ----
`timescale 1ns/100ps
module ecmai_monitor #(
   parameter INTERVAL_CYCLES = 40000
) (
   input wire clk,
   input wire reset_n,
   input wire frame_sync_lost,
   input wire slot16_strobe,
   input wire psel,
   input wire penable,
   input wire pready,
   input wire pslverr,
   input wire sig_multiframe_lost,
   input wire red_alarm,
   input wire slot16_alarm
);
   // Cycle ages; 32 bits cannot wrap within any run
   int since_loss;
   int since_strobe;
   int up;
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         since_loss   <= 0;
         since_strobe <= 100;
         up           <= 0;
      end else begin
         since_loss   <= frame_sync_lost ? 0 : since_loss + 1;
         since_strobe <= slot16_strobe ? 0 : since_strobe + 1;
         up           <= up + 1;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   setup_ready_a: assert property (psel && !penable |=> pready) else $error("no ready after setup");
   ready_access_a: assert property (pready |-> psel && penable) else $error("ready outside access");
   slverr_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
   loss_drop_a: assert property (frame_sync_lost [*3] |-> ##[0:3] sig_multiframe_lost)
      else $error("multiframe kept after frame loss");
   align_strobe_a: assert property ($fell(sig_multiframe_lost) |-> since_strobe < 4)
      else $error("alignment without slot 16 byte");
   red_rise_a: assert property ($rose(red_alarm) |-> since_loss < 3 * INTERVAL_CYCLES + 8)
      else $error("red alarm without recent loss");
   red_clear_a: assert property ($fell(red_alarm) |-> since_loss > 20 * INTERVAL_CYCLES)
      else $error("red alarm cleared too soon");
   ts16_rise_a: assert property ($rose(slot16_alarm) |-> up > 20 * INTERVAL_CYCLES)
      else $error("slot 16 alarm too soon");
   cover property ($rose(red_alarm));
   cover property ($fell(sig_multiframe_lost));
   cover property (pslverr);
   cover property ($rose(slot16_alarm));
endmodule
bind ecmai_top ecmai_monitor #(.INTERVAL_CYCLES(INTERVAL_CYCLES)) u_mon (.clk(clk), .reset_n(reset_n),
   .frame_sync_lost(frame_sync_lost), .slot16_strobe(slot16_strobe), .psel(psel), .penable(penable),
   .pready(pready), .pslverr(pslverr), .sig_multiframe_lost(sig_multiframe_lost), .red_alarm(red_alarm),
   .slot16_alarm(slot16_alarm));

// ---- verif/ecmai_line_model.sv ----
`timescale 1ns/100ps
module ecmai_line_model (
   input  wire logic       clk,
   output logic            slot16_strobe,
   output logic      [7:0] slot16_byte,
   output logic            line_bit,
   output logic            line_bit_valid
);
   initial begin
      slot16_strobe  = 0;
      slot16_byte    = 8'h00;
      line_bit       = 0;
      line_bit_valid = 0;
   end
   // Frames are compressed to four cycles; the byte is inverted between strobes
   task send_ts16(input logic [7:0] b);
      slot16_strobe <= 1;
      slot16_byte   <= b;
      @(posedge clk);
      slot16_strobe <= 0;
      slot16_byte   <= ~b;
      repeat (3) @(posedge clk);
   endtask
   task send_bits(input int n, input logic v);
      repeat (n) begin
         line_bit_valid <= 1;
         line_bit       <= v;
         @(posedge clk);
      end
      line_bit_valid <= 0;
      line_bit       <= ~v;
   endtask
endmodule

// ---- verif/e1_cas_multiframe_alarm_integrator_bench.sv ----
`timescale 1ns/100ps
`include "ecmai_map.vh"
module e1_cas_multiframe_alarm_integrator_bench;
   localparam int IV = 20;
   logic clk, reset_n, fsl, psel, penable, pwrite, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, rd;
   wire  [31:0] prdata;
   wire  [7:0]  sb;
   wire         pready, pslverr, stc, smf, ais, red, ts16, ss, lb, lv;
   int num_errors = 0, n_checks = 0, cycles = 0;
   always #50 clk = ~clk;
   ecmai_line_model u_line (.clk(clk), .slot16_strobe(ss), .slot16_byte(sb), .line_bit(lb), .line_bit_valid(lv));
   ecmai_top #(.INTERVAL_CYCLES(IV)) u_dut (.clk(clk), .reset_n(reset_n), .line_bit(lb), .line_bit_valid(lv),
      .frame_sync_lost(fsl), .slot16_strobe(ss), .slot16_byte(sb), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .status_change(stc), .sig_multiframe_lost(smf), .all_ones_alarm(ais), .red_alarm(red),
      .slot16_alarm(ts16));
   task end_of_test;
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      psel    <= 1;
      penable <= 0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge clk);
      penable <= 1;
      @(posedge clk);
      // Values read here are those sampled at this rising edge
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      rd = prdata;
      er = pslverr;
      psel    <= 0;
      penable <= 0;
      @(posedge clk);
   endtask
   task mf(input logic [7:0] f0);
      repeat (15) u_line.send_ts16(8'h5b);
      u_line.send_ts16(f0);
   endtask
   task ev(input int b, input logic e);
      apb(0, `ECMAI_EVENT_ADDR, 0);
      chk({31'h0, rd[b]}, {31'h0, e});
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         end_of_test;
      end
   end
   initial begin
      clk = 1'b0;
      reset_n <= 1'b0;
      fsl <= 1'b0;
      psel <= 1'b0;
      penable <= 1'b0;
      pwrite <= 1'b0;
      paddr <= 12'h0;
      pwdata <= 32'h0;
      repeat (5) @(posedge clk);
      reset_n <= 1;
      @(posedge clk);
      apb(0, `ECMAI_STATUS_ADDR, 0);
      chk(rd, 32'h2);
      apb(0, 12'h0f0, 0);
      chk({rd[30:0], er}, 32'h1);
      apb(1, `ECMAI_CHG_MASK_ADDR, 32'h2);
      chk({31'h0, stc}, 0);
      $display("reset and bus test done");
      repeat (160) u_line.send_ts16(8'hff);
      chk({31'h0, ts16}, 1);
      ev(1, 1);
      apb(1, `ECMAI_CTRL_ADDR, 0);
      // A short frame loss restarts the miss count left by the all-ones frames
      fsl <= 1;
      repeat (4) @(posedge clk);
      fsl <= 0;
      repeat (4) @(posedge clk);
      repeat (14) u_line.send_ts16(8'h5b);
      u_line.send_ts16(8'h0b);
      chk({31'h0, smf}, 1);
      mf(8'h0b);
      chk({31'h0, smf}, 0);
      chk({31'h0, stc}, 1);
      mf(8'h8b);
      chk({31'h0, smf}, 0);
      ev(0, 1);
      mf(8'h8b);
      chk({31'h0, smf}, 1);
      $display("first search test done");
      apb(1, `ECMAI_CTRL_ADDR, 1);
      u_line.send_ts16(8'h5b);
      u_line.send_ts16(8'h0b);
      chk({31'h0, smf}, 0);
      mf(8'h0f);
      apb(0, `ECMAI_STATUS_ADDR, 0);
      chk({31'h0, rd[5]}, 0);
      mf(8'h0f);
      apb(0, `ECMAI_STATUS_ADDR, 0);
      chk({31'h0, rd[5]}, 1);
      repeat (16) u_line.send_ts16(8'h00);
      chk({31'h0, smf}, 1);
      u_line.send_ts16(8'h5b);
      u_line.send_ts16(8'h0b);
      apb(1, `ECMAI_CTRL_ADDR, 3);
      repeat (16) u_line.send_ts16(8'h00);
      chk({31'h0, smf}, 0);
      repeat (16) u_line.send_ts16(8'h00);
      chk({31'h0, smf}, 1);
      u_line.send_ts16(8'h5b);
      u_line.send_ts16(8'h0b);
      chk({31'h0, smf}, 0);
      fsl <= 1;
      repeat (5) @(posedge clk);
      chk({31'h0, smf}, 1);
      $display("second search test done");
      repeat (22 * IV) @(posedge clk);
      chk({31'h0, red}, 0);
      repeat (6 * IV) @(posedge clk);
      chk({31'h0, red}, 1);
      repeat (17 * IV) @(posedge clk);
      fsl <= 0;
      repeat (22 * IV) @(posedge clk);
      chk({31'h0, red}, 1);
      repeat (6 * IV) @(posedge clk);
      chk({31'h0, red}, 0);
      $display("red alarm test done");
      u_line.send_bits(520, 1);
      ev(2, 1);
      apb(1, `ECMAI_EVENT_ADDR, 32'h4);
      u_line.send_bits(600, 0);
      ev(2, 0);
      chk({31'h0, ais}, 0);
      $display("all ones test done");
      end_of_test;
   end
endmodule
